// ---- hw/tch_pkg.sv ----
// package: constants and types for the alarm hysteresis and identity bank
package tch_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_OUT = 3;
  localparam int NUM_REMOTE = 4;
  localparam logic [7:0] CMD_HYST = 8'h5A;
  localparam logic [7:0] CMD_MODEL = 8'h30;
  localparam logic [7:0] CMD_BETA = 8'h31;
  localparam logic [7:0] CMD_MAKER = 8'hFE;
  localparam logic [7:0] CMD_REV = 8'hFF;
  localparam logic [4:0] HYST_RESET = 5'h0A;
  localparam logic [3:0] MODEL_RESET = 4'h0;
  localparam logic [3:0] BETA_RESET = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] ZERO_TOP = 3'h0;
  // arbitrary identity values
  localparam logic [7:0] MAKER_ID_DEF = 8'h5C;
  localparam logic [7:0] REV_ID_DEF = 8'h23;

  typedef struct packed {
    logic [4:0] hyst;
    logic [3:0] model;
    logic [3:0] beta;
    logic [7:0] rdata;
    logic [NUM_OUT-1:0] alarm;
  } tch_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } tch_req_type;
endpackage : tch_pkg

// ---- hw/tch_cmp.sv ----
// one channel comparator with shared falling-temperature hysteresis
`timescale 1ns/1ns
`default_nettype none
module tch_cmp
  import tch_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_reset_n, // sync reset
  input wire logic i_done, // conversion complete
  input wire logic [7:0] i_temp, // reading, whole degrees
  input wire logic [7:0] i_limit, // alarm limit
  input wire logic [4:0] i_hyst, // hysteresis
  output logic o_event // error event
);
  logic event_q;
  logic event_d;
  logic [8:0] release_lvl;

  // extra bit catches limit minus hysteresis wrapping below zero; release is then blocked
  assign release_lvl = {1'b0, i_limit} - {4'h0, i_hyst};

  always_comb begin
    event_d = event_q;
    if (i_done) begin
      if (!event_q && i_temp > i_limit) begin
        event_d = 1'b1;
      end else if (event_q && !release_lvl[8] &&
                   {1'b0, i_temp} < release_lvl) begin
        event_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_d;
    end
  end

  assign o_event = event_q;

  a_event_rise: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_done && !event_q && i_temp > i_limit) |=> o_event)
    else $error("event not raised above limit");
  a_event_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (event_q && i_done && {1'b0, i_temp} >= release_lvl) |=> o_event)
    else $error("event released inside hysteresis band");
  a_event_quiet: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_done |=> $stable(o_event))
    else $error("event changed without conversion");
endmodule : tch_cmp
`default_nettype wire

// ---- hw/tch_regs.sv ----
// register bank: shared hysteresis, model select, identity, alarm outputs
`timescale 1ns/1ns
`default_nettype none
module tch_regs
  import tch_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_reset_n, // sync reset
  input wire tch_req_type i_req, // command-byte access
  output logic [7:0] o_rdata, // read data, registered
  input wire logic [NUM_CH-1:0] i_conv_done, // per channel conversion done
  input wire logic [NUM_CH*8-1:0] i_temp, // readings, ch0 local
  input wire logic [NUM_CH*8-1:0] i_limit_a, // limits for output a
  input wire logic [NUM_CH*8-1:0] i_limit_bc, // limits for outputs b,c
  input wire logic [NUM_OUT*NUM_CH-1:0] i_mask, // masks, 1 blocks
  output logic [NUM_REMOTE-1:0] o_model_sel, // 1 processor model
  output logic [NUM_REMOTE-1:0] o_beta_en, // beta compensation enable
  output logic o_critical_alarm_out_a, // alarm a, active high
  output logic o_critical_alarm_out_b, // alarm b, active high
  output logic o_critical_alarm_out_c // alarm c, active high
);
  tch_state_type s_q;
  tch_state_type s_d;
  logic [NUM_CH-1:0] ev_a;
  logic [NUM_CH-1:0] ev_bc;

  // outputs b and c share limits, so one comparator set serves both
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tch_cmp u_cmp_a (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_done(i_conv_done[g]),
        .i_temp(i_temp[g*8 +: 8]),
        .i_limit(i_limit_a[g*8 +: 8]),
        .i_hyst(s_q.hyst),
        .o_event(ev_a[g])
      );
      tch_cmp u_cmp_bc (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_done(i_conv_done[g]),
        .i_temp(i_temp[g*8 +: 8]),
        .i_limit(i_limit_bc[g*8 +: 8]),
        .i_hyst(s_q.hyst),
        .o_event(ev_bc[g])
      );
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    if (i_req.wr) begin
      unique case (i_req.cmd)
        CMD_HYST: s_d.hyst = i_req.wdata[4:0];
        CMD_MODEL: s_d.model = i_req.wdata[3:0];
        CMD_BETA: s_d.beta = i_req.wdata[3:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    if (i_req.rd) begin
      unique case (i_req.cmd)
        CMD_HYST: s_d.rdata = {ZERO_TOP, s_q.hyst};
        CMD_MODEL: s_d.rdata = {4'h0, s_q.model};
        CMD_BETA: s_d.rdata = {4'h0, s_q.beta};
        CMD_MAKER: s_d.rdata = MAKER_ID_DEF;
        CMD_REV: s_d.rdata = REV_ID_DEF;
        default: s_d.rdata = ZERO_BYTE;
      endcase
    end
    // unmasked events only; a set mask bit removes the channel
    s_d.alarm[0] = |(ev_a & ~i_mask[0 +: NUM_CH]);
    s_d.alarm[1] = |(ev_bc & ~i_mask[NUM_CH +: NUM_CH]);
    s_d.alarm[2] = |(ev_bc & ~i_mask[2*NUM_CH +: NUM_CH]);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_q.hyst <= HYST_RESET;
      s_q.model <= MODEL_RESET;
      s_q.beta <= BETA_RESET;
      s_q.rdata <= ZERO_BYTE;
      s_q.alarm <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_model_sel = s_q.model;
  // beta policy is the host's choice; the bank only stores it
  assign o_beta_en = s_q.beta;
  assign o_critical_alarm_out_a = s_q.alarm[0];
  assign o_critical_alarm_out_b = s_q.alarm[1];
  assign o_critical_alarm_out_c = s_q.alarm[2];

  // access shapes the checks below are built from
  sequence s_hyst_wr;
    i_req.wr && !i_req.rd && i_req.cmd == CMD_HYST;
  endsequence
  sequence s_bus_idle;
    !i_req.wr && !i_req.rd;
  endsequence
  sequence s_hyst_rd;
    i_req.rd && !i_req.wr && i_req.cmd == CMD_HYST;
  endsequence
  sequence s_model_wr;
    i_req.wr && i_req.cmd == CMD_MODEL;
  endsequence
  sequence s_beta_wr;
    i_req.wr && i_req.cmd == CMD_BETA;
  endsequence
  // any command byte the bank does not decode
  sequence s_unknown_rd;
    i_req.rd && i_req.cmd != CMD_HYST && i_req.cmd != CMD_MODEL &&
    i_req.cmd != CMD_BETA && i_req.cmd != CMD_MAKER &&
    i_req.cmd != CMD_REV;
  endsequence

  a_reset_clear: assert property (
    @(posedge i_core_clk)
    !i_reset_n |=> (s_q.hyst == HYST_RESET && o_model_sel == MODEL_RESET &&
      o_beta_en == BETA_RESET && o_rdata == ZERO_BYTE && s_q.alarm == '0))
    else $error("state not cleared by reset");

  a_hyst_top: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_req.rd && i_req.cmd == CMD_HYST) |=> o_rdata[7:5] == ZERO_TOP)
    else $error("hysteresis upper bits not zero");

  // host leaves one idle cycle between accesses
  a_hyst_write: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    s_hyst_wr ##1 s_bus_idle ##1 s_hyst_rd
    |=> o_rdata[4:0] == $past(i_req.wdata[4:0], 3))
    else $error("hysteresis write not read back");

  a_hyst_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(i_req.wr && i_req.cmd == CMD_HYST) |=> $stable(s_q.hyst))
    else $error("hysteresis changed without write");

  a_mask_block: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (&i_mask[0 +: NUM_CH]) |=> !o_critical_alarm_out_a)
    else $error("masked event reached alarm a");

  a_mask_b_block: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (&i_mask[NUM_CH +: NUM_CH]) |=> !o_critical_alarm_out_b)
    else $error("masked event reached alarm b");

  a_mask_c_block: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (&i_mask[2*NUM_CH +: NUM_CH]) |=> !o_critical_alarm_out_c)
    else $error("masked event reached alarm c");

  a_alarm_pass: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (ev_bc[0] && !i_mask[NUM_CH]) |=> o_critical_alarm_out_b)
    else $error("unmasked event missing on alarm b");

  a_alarm_a_pass: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (ev_a[0] && !i_mask[0]) |=> o_critical_alarm_out_a)
    else $error("unmasked event missing on alarm a");

  a_alarm_c_pass: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (ev_bc[0] && !i_mask[2*NUM_CH]) |=> o_critical_alarm_out_c)
    else $error("unmasked event missing on alarm c");

  a_quiet_a: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(|ev_a) |=> !o_critical_alarm_out_a)
    else $error("alarm a without any event");

  a_quiet_b: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(|ev_bc) |=> !o_critical_alarm_out_b)
    else $error("alarm b without any event");

  a_quiet_c: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(|ev_bc) |=> !o_critical_alarm_out_c)
    else $error("alarm c without any event");

  a_model_write: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    s_model_wr |=> o_model_sel == $past(i_req.wdata[3:0]))
    else $error("model select not updated");

  a_model_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(i_req.wr && i_req.cmd == CMD_MODEL) |=> $stable(o_model_sel))
    else $error("model select changed without write");

  a_model_read: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_req.rd && i_req.cmd == CMD_MODEL) |=> o_rdata == 8'($past(o_model_sel)))
    else $error("model select read back wrong");

  a_beta_write: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    s_beta_wr |=> o_beta_en == $past(i_req.wdata[3:0]))
    else $error("beta enable not updated");

  a_beta_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !(i_req.wr && i_req.cmd == CMD_BETA) |=> $stable(o_beta_en))
    else $error("beta enable changed without write");

  a_beta_read: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_req.rd && i_req.cmd == CMD_BETA) |=> o_rdata == 8'($past(o_beta_en)))
    else $error("beta enable read back wrong");

  // identity bytes are constants, so writes to them cannot stick
  a_maker_read: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_req.rd && i_req.cmd == CMD_MAKER) |=> o_rdata == MAKER_ID_DEF)
    else $error("maker identity read wrong");

  a_rev_read: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_req.rd && i_req.cmd == CMD_REV) |=> o_rdata == REV_ID_DEF)
    else $error("revision identity read wrong");

  a_unknown_read: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    s_unknown_rd |=> o_rdata == ZERO_BYTE)
    else $error("unknown command read not zero");

  a_rdata_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data changed without read");
endmodule : tch_regs
`default_nettype wire

// ---- sim/tch_host.sv ----
// host model issuing command-byte register accesses
`timescale 1ns/1ns
`default_nettype none
module tch_host
  import tch_pkg::*;
(
  input wire logic i_core_clk, // core clock
  output var tch_req_type o_req, // request to bank
  input wire logic [7:0] i_rdata // read data
);
  initial o_req = '0;
  // one strobe per call, idle cycle before it so strobes never merge
  task automatic acc(input logic wr, input logic [7:0] cmd,
      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_core_clk);
    #10 o_req = '{wr: wr, rd: !wr, cmd: cmd, wdata: wd};
    @(posedge i_core_clk);
    #10 rd = i_rdata;
    o_req = '0;
  endtask : acc
  task automatic cfg(input logic [3:0] model, input logic [3:0] want);
    logic [7:0] rd;
    acc(1'b1, CMD_MODEL, {4'h0, model}, rd);
    // compensation only on processor-model channels
    acc(1'b1, CMD_BETA, {4'h0, model & want}, rd);
  endtask : cfg
endmodule : tch_host
`default_nettype wire

// ---- sim/tch_regs_tb.sv ----
// self-checking bench for the hysteresis and identity bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module tch_regs_tb;
  import tch_pkg::*;
  logic clk = 0, rst_n = 0;
  tch_req_type req;
  logic [7:0] rdata, rd, lim = 8'h50, t;
  logic [4:0] hy = HYST_RESET, ev = '0, done = '0;
  logic [39:0] temp = '0, lima = '0, limbc = '0;
  logic [14:0] mask = '0;
  logic [3:0] msel, ben;
  logic aa, ab, ac;
  int failures = 0, checks_done = 0, seed = 32'hbc092f3a, g = 0;
  initial forever #50 clk = ~clk;
  tch_host tch_host_inst(.i_core_clk(clk), .o_req(req), .i_rdata(rdata));
  tch_regs tch_regs_inst(.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .o_rdata(rdata), .i_conv_done(done), .i_temp(temp), .i_limit_a(lima),
    .i_limit_bc(limbc), .i_mask(mask), .o_model_sel(msel), .o_beta_en(ben),
    .o_critical_alarm_out_a(aa), .o_critical_alarm_out_b(ab),
    .o_critical_alarm_out_c(ac));
  function automatic logic [2:0] want(input logic [4:0] e,
      input logic [14:0] m);
    return {|(e & ~m[14:10]), |(e & ~m[9:5]), |(e & ~m[4:0])};
  endfunction : want
  task automatic conv(input logic [7:0] tv, input logic d);
    temp = {5{tv}};
    done[g] = d;
    @(posedge clk);
    #10 done = '0;
    if (d && tv > lim) ev[g] = 1'b1;
    else if (d && int'(tv) < int'(lim) - int'(hy)) ev[g] = 1'b0;
    repeat (2) @(posedge clk);
    #10 `CHK({ac, ab, aa}, want(ev, mask))
  endtask : conv
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #1_000_000 failures++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    #10 rst_n = 1;
    tch_host_inst.acc(0, CMD_HYST, 0, rd); `CHK(rd, 8'h0A)
    tch_host_inst.acc(1, CMD_MAKER, 8'hFF, rd);
    tch_host_inst.acc(0, CMD_MAKER, 0, rd); `CHK(rd, MAKER_ID_DEF)
    tch_host_inst.acc(0, CMD_REV, 0, rd); `CHK(rd, REV_ID_DEF)
    tch_host_inst.acc(0, 8'h77, 0, rd); `CHK(rd, 8'h00)
    `CHK({msel, ben}, 8'h00)
    for (int i = 0; i < 40; i++) begin
      t = (i == 0) ? 8'hFF : 8'($random(seed));
      tch_host_inst.acc(1, CMD_HYST, t, rd);
      hy = t[4:0];
      tch_host_inst.acc(0, CMD_HYST, 0, rd); `CHK(rd, {3'h0, hy})
      tch_host_inst.cfg(t[3:0], t[7:4]);
      `CHK({msel, ben}, {t[3:0], t[3:0] & t[7:4]})
      tch_host_inst.acc(0, CMD_MODEL, 0, rd); `CHK(rd, {4'h0, t[3:0]})
      tch_host_inst.acc(0, CMD_BETA, 0, rd);
      `CHK(rd, {4'h0, t[3:0] & t[7:4]})
      lim = 8'($random(seed));
      lima = {5{lim}};
      limbc = {5{lim}};
      mask = 15'($random(seed));
      g = {$random(seed)} % NUM_CH;
      conv(lim + 8'h01, 1'b1);
      conv(lim - {3'h0, hy}, 1'b1);
      conv(8'h00, 1'b0);
      conv(lim - {3'h0, hy} - 8'h01, 1'b1);
      conv(8'($random(seed)), 1'b1);
    end
    conclude();
  end
endmodule : tch_regs_tb
`default_nettype wire
